// >>> logic/sfa_pkg.sv
// Constants and types of the fault alert serial slave
package sfa_pkg;

    // ==========================================================
    // Serial address (7 bits, without the direction bit) and switch address prefix (5 bits)
    localparam logic [6:0] SFA_POINTER_ADDR = 7'h0C;
    localparam logic [4:0] SFA_SWITCH_PREFIX = 5'h14;

    // ==========================================================
    // Status byte field positions
    localparam int SFA_SEVERE_POS = 7;
    localparam int SFA_LOGIC_A_POS = 6;
    localparam int SFA_PROG_A_POS = 5;
    localparam int SFA_LOGIC_B_POS = 4;
    localparam int SFA_PROG_B_POS = 3;
    localparam int SFA_COUNT_POS = 2;

    // ==========================================================
    // Reset and constant values
    localparam logic [7:0] SFA_RETURN_RESET = 8'h00;
    localparam logic [4:0] SFA_FLAGS_RESET = 5'h00;
    localparam logic       SFA_CHANNEL_COUNT = 1'b0;
    localparam logic [1:0] SFA_RESERVED_BITS = 2'h0;
    localparam logic       SFA_PAD_BIT = 1'b0;
    localparam logic [3:0] SFA_BITS_PER_BYTE = 4'h8;

    // ==========================================================
    // Fault inputs from the protection circuits
    typedef struct packed {
        logic thermal;
        logic uvlo;
        logic logic_a;
        logic prog_a;
        logic logic_b;
        logic prog_b;
    } sfa_fault_type;

    // Sampled pin group
    typedef struct packed {
        logic          scl;
        logic          sda;
        sfa_fault_type fault;
        logic          sel;
    } sfa_pins_type;

    // Serial slave states
    typedef enum logic [2:0] {
        SFA_IDLE, SFA_ADDR, SFA_ADDR_ACK, SFA_TX, SFA_TX_ACK,
        SFA_RX, SFA_RX_ACK, SFA_IGNORE
    } sfa_state_type;

endpackage : sfa_pkg

// >>> logic/sfa_slave.sv
// Fault alert serial slave: status read, return address read, alert
//
// Functional notes
// R1 - Valid read address: acknowledge, then shift data out with host clock.
// R2 - Host ends each read by not acknowledging after the data byte.
// R3 - Repeated start after a write is accepted; direction may change.
// R4 - Never a master; only unsolicited action is pulling alert low.
// R5 - Alert raised only for overcurrent, undervoltage or thermal faults.
// R6 - Fault drives alert low at once and keeps it latched.
// R7 - Momentary fault stays recorded with alert held until serviced.
// R8 - Pointer-address read releases alert and returns own address.
// R9 - Pointer byte: address in bits 7..1, bit 0 zero, resets zero.
// R10 - Return address encodes reporting channel and select pin.
// R11 - Persistent fault reasserts alert without reloading fault flags.
// R12 - Flags hold only the first occurrence until a status read.
// R13 - Spurious alert at start is cleared by a pointer-address read.
// R14 - Read at channel A address shifts status and clears flags.
// R15 - Fault still present after the clearing read latches again.
// R16 - Bit 7 latched severe flag for thermal or undervoltage lockout.
// R17 - Bits 6 and 4 latched logic supply faults, channels A and B.
// R18 - Bits 5 and 3 latched programming supply faults, A and B.
// R19 - Bit 2 reads zero for two channels; bits 1 and 0 read zero.
// R20 - Logic supply reset clears all registers; switch supplies do not.
// R21 - Lower address wins arbitration; loser withholds and keeps alert.
// R22 - Host treats the alert input as a level.
// R23 - Host must not drop data before clock while writing.
// R24 - Writes to the pointer address are refused.
// R25 - Fault mask suppresses alerts from both channels.
// R26 - Alert is an open-drain enable, low while an alert is pending.
`timescale 1ns/100ps

module sfa_slave
    import sfa_pkg::*;
(
    // Clock, reset, enable
    input  wire logic          clk,
    input  wire logic          nrst,
    input  wire logic          ce,
    // Serial bus pins
    input  wire logic          serial_clock_pin,
    input  wire logic          serial_data_in,
    output logic               serial_data_out,
    output logic               serial_data_oe_n,
    // Alert pin
    output logic               alert_out,
    output logic               alert_oe_n,
    // Fault sensing, select pin and mask from the command side
    input  wire sfa_fault_type fault_in,
    input  wire logic          addr_select_pin,
    input  wire logic          fault_alert_mask,
    // Received command byte for the write side
    output logic [7:0]         cmd_byte,
    output logic               cmd_strobe,
    output logic               cmd_channel_b
);

    // ==========================================================
    // Pin synchronisers: a change counts once stages 2 and 3 agree
    sfa_pins_type pin_raw, sync1, sync2, sync3, filt, filt_q, next_filt;
    assign pin_raw = '{scl: serial_clock_pin, sda: serial_data_in,
                       fault: fault_in, sel: addr_select_pin};
    // Filtered level takes each bit where the last two stages agree
    always_comb begin
        next_filt = (sync2 & sync3) | (filt & (sync2 | sync3));
    end
    // Synchroniser and filter registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            sync1  <= '{scl: 1'b1, sda: 1'b1, fault: '0, sel: 1'b0};
            sync2  <= '{scl: 1'b1, sda: 1'b1, fault: '0, sel: 1'b0};
            sync3  <= '{scl: 1'b1, sda: 1'b1, fault: '0, sel: 1'b0};
            filt   <= '{scl: 1'b1, sda: 1'b1, fault: '0, sel: 1'b0};
            filt_q <= '{scl: 1'b1, sda: 1'b1, fault: '0, sel: 1'b0};
        end else if (ce) begin
            sync1  <= pin_raw;
            sync2  <= sync1;
            sync3  <= sync2;
            filt   <= next_filt;
            filt_q <= filt;
        end
    end
    // Bus events on the filtered levels
    logic scl_rise, scl_fall, bus_start, bus_stop;
    assign scl_rise  = filt.scl & ~filt_q.scl;
    assign scl_fall  = ~filt.scl & filt_q.scl;
    assign bus_start = filt.scl & filt_q.scl & filt_q.sda & ~filt.sda;
    assign bus_stop  = filt.scl & filt_q.scl & ~filt_q.sda & filt.sda;

    // ==========================================================
    // Fault flags, alert and return address
    logic [4:0]    flags, next_flags;
    logic [7:0]    ret_byte, next_ret_byte;
    logic          alert_pend, next_alert_pend;
    logic          fault_any, alert_set, clr_alert, clr_flags;
    logic [7:0]    status_byte;
    logic          chan_b;
    sfa_state_type st, next_st;
    logic          is_ip;
    assign fault_any = |filt.fault;                             // see R5
    assign alert_set = fault_any & ~fault_alert_mask;           // see R25
    assign chan_b    = ~(filt.fault.logic_a | filt.fault.prog_a)
                     & (filt.fault.logic_b | filt.fault.prog_b);
    // Byte completed to a host that then withholds or gives acknowledge
    assign clr_alert = (st == SFA_TX_ACK) & scl_rise & is_ip
                     & ~bus_start & ~bus_stop;                  // see R8 R13
    assign clr_flags = (st == SFA_TX_ACK) & scl_rise & ~is_ip
                     & ~bus_start & ~bus_stop;                  // see R14
    // Status byte: latched flags above constant low bits
    assign status_byte = {flags, SFA_CHANNEL_COUNT,
                          SFA_RESERVED_BITS};                   // see R19
    // Next flag, alert and return address values; a set beats a clear
    always_comb begin
        next_flags      = clr_flags ? SFA_FLAGS_RESET : flags;
        next_ret_byte   = clr_alert ? SFA_RETURN_RESET : ret_byte;
        next_alert_pend = alert_pend & ~clr_alert;
        // Only the first occurrence is captured, again after a clear
        if (next_flags == SFA_FLAGS_RESET && fault_any) begin  // see R12
            next_flags = {filt.fault.thermal | filt.fault.uvlo, // see R16
                          filt.fault.logic_a,                   // see R17
                          filt.fault.prog_a,                    // see R18
                          filt.fault.logic_b,
                          filt.fault.prog_b};                   // see R15
        end
        if (alert_set) begin                                    // see R11
            next_alert_pend = 1'b1;                             // see R6
            if (next_ret_byte == SFA_RETURN_RESET) begin
                next_ret_byte = {SFA_SWITCH_PREFIX, filt.sel,
                                 chan_b, SFA_PAD_BIT};          // see R10
            end
        end
    end
    // Registers cleared by the logic supply reset, otherwise only by reads
    always_ff @(posedge clk) begin
        if (!nrst) begin                                        // see R20
            flags      <= SFA_FLAGS_RESET;
            ret_byte   <= SFA_RETURN_RESET;                     // see R9
            alert_pend <= 1'b0;
        end else if (ce) begin
            flags      <= next_flags;
            ret_byte   <= next_ret_byte;
            alert_pend <= next_alert_pend;                      // see R7
        end
    end
    // Open-drain alert, pulled low while pending
    assign alert_out  = 1'b0;
    assign alert_oe_n = ~alert_pend;                            // see R26

    // ==========================================================
    // Serial slave state machine
    logic [3:0] cnt, next_cnt;
    logic [7:0] shreg, next_shreg, txreg, next_txreg, next_cmd_byte;
    logic       drv, next_drv, rw, next_rw, next_is_ip;
    logic       macked, next_macked, next_cmd_strobe, next_cmd_chb;
    logic [6:0] own_read;
    assign own_read = {SFA_SWITCH_PREFIX, filt.sel, 1'b0};      // see R14
    // Next bus state; start and stop override any state
    always_comb begin
        next_st         = st;
        next_cnt        = cnt;
        next_shreg      = shreg;
        next_txreg      = txreg;
        next_drv        = drv;
        next_rw         = rw;
        next_is_ip      = is_ip;
        next_macked     = macked;
        next_cmd_strobe = 1'b0;
        next_cmd_byte   = cmd_byte;
        next_cmd_chb    = cmd_channel_b;
        if (bus_start) begin
            next_st  = SFA_ADDR;                                // see R3
            next_cnt = '0;
            next_drv = 1'b0;
        end else if (bus_stop) begin
            next_st  = SFA_IDLE;
            next_drv = 1'b0;
        end else begin
            case (st)
                SFA_ADDR: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], filt.sda};
                        next_cnt   = cnt + 4'h1;
                    end else if (scl_fall && cnt == SFA_BITS_PER_BYTE) begin
                        next_st = SFA_IGNORE;
                        next_rw = shreg[0];
                        next_is_ip = (shreg[7:1] == SFA_POINTER_ADDR);
                        // Pointer only answers reads while alerting
                        if ((shreg == {SFA_POINTER_ADDR, 1'b1} && alert_pend)
                            || shreg == {own_read, 1'b1}
                            || (shreg[7:2] == {SFA_SWITCH_PREFIX, filt.sel}
                                && !shreg[0])) begin            // see R24
                            next_st  = SFA_ADDR_ACK;
                            next_drv = 1'b1;                    // see R1
                        end
                    end
                end
                SFA_ADDR_ACK: begin
                    if (scl_fall) begin
                        next_cnt = '0;
                        if (rw) begin
                            next_txreg = is_ip ? ret_byte : status_byte;
                            next_drv   = is_ip ? ~ret_byte[7]
                                               : ~status_byte[7];
                            next_st    = SFA_TX;                // see R1
                        end else begin
                            next_cmd_chb = shreg[1];
                            next_drv     = 1'b0;
                            next_st      = SFA_RX;
                        end
                    end
                end
                SFA_TX: begin
                    if (scl_rise) begin
                        next_cnt = cnt + 4'h1;
                        // Released one seen low: arbitration lost
                        if (!drv && !filt.sda) begin            // see R21
                            next_st = SFA_IGNORE;
                        end
                    end else if (scl_fall) begin
                        if (cnt == SFA_BITS_PER_BYTE) begin
                            next_drv = 1'b0;
                            next_st  = SFA_TX_ACK;
                        end else begin
                            next_txreg = {txreg[6:0], 1'b0};
                            next_drv   = ~txreg[6];
                        end
                    end
                end
                SFA_TX_ACK: begin
                    if (scl_rise) begin
                        next_macked = ~filt.sda;                // see R2
                    end else if (scl_fall) begin
                        if (macked) begin
                            next_txreg = is_ip ? ret_byte : status_byte;
                            next_drv   = is_ip ? ~ret_byte[7]
                                               : ~status_byte[7];
                            next_cnt   = '0;
                            next_st    = SFA_TX;
                        end else begin
                            next_st = SFA_IGNORE;
                        end
                    end
                end
                SFA_RX: begin
                    if (scl_rise) begin
                        next_shreg = {shreg[6:0], filt.sda};
                        next_cnt   = cnt + 4'h1;
                    end else if (scl_fall && cnt == SFA_BITS_PER_BYTE) begin
                        next_drv = 1'b1;
                        next_st  = SFA_RX_ACK;
                    end
                end
                SFA_RX_ACK: begin
                    if (scl_fall) begin
                        next_drv        = 1'b0;
                        next_cmd_byte   = shreg;
                        next_cmd_strobe = 1'b1;
                        next_st         = SFA_IGNORE;
                    end
                end
                default: begin
                    next_drv = 1'b0;
                end
            endcase
        end
    end
    // Bus state registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st            <= SFA_IDLE;
            cnt           <= '0;
            shreg         <= '0;
            txreg         <= '0;
            drv           <= 1'b0;
            rw            <= 1'b0;
            is_ip         <= 1'b0;
            macked        <= 1'b0;
            cmd_strobe    <= 1'b0;
            cmd_byte      <= '0;
            cmd_channel_b <= 1'b0;
        end else if (ce) begin
            st            <= next_st;
            cnt           <= next_cnt;
            shreg         <= next_shreg;
            txreg         <= next_txreg;
            drv           <= next_drv;
            rw            <= next_rw;
            is_ip         <= next_is_ip;
            macked        <= next_macked;
            cmd_strobe    <= next_cmd_strobe;
            cmd_byte      <= next_cmd_byte;
            cmd_channel_b <= next_cmd_chb;
        end
    end

    // Data pin is open drain, only ever pulled low
    assign serial_data_out  = 1'b0;
    assign serial_data_oe_n = ~drv;                             // see R4

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_alert_on_fault: assert property (ce && alert_set |=> !alert_oe_n) // see R6
        else $error("alert not low after unmasked fault");
    a_alert_holds: assert property (                            // see R7
        ce && alert_pend && !clr_alert |=> alert_pend)
        else $error("alert dropped without pointer read");
    a_alert_release: assert property (                          // see R8
        ce && clr_alert && !alert_set |=> alert_oe_n)
        else $error("alert not released by pointer read");
    a_flags_frozen: assert property (                           // see R12
        ce && flags != 5'h00 && !clr_flags |=> $stable(flags))
        else $error("latched flags changed before clear");
    a_flags_clear: assert property (                            // see R14
        ce && clr_flags && !fault_any |=> flags == 5'h00)
        else $error("status read did not clear flags");
    a_low_bits_zero: assert property (                          // see R19
        status_byte[2:0] == 3'h0 && ret_byte[0] == 1'b0)
        else $error("constant bits not zero");
    a_ret_prefix: assert property (                             // see R10
        ret_byte != 8'h00 |-> ret_byte[7:3] == 5'h14 && !alert_oe_n)
        else $error("return address prefix wrong");
    a_no_ip_write: assert property (                            // see R24
        st == SFA_ADDR_ACK |-> !(is_ip && !rw))
        else $error("write to pointer address acknowledged");
    a_lost_release: assert property (                           // see R21
        ce && st == SFA_TX && scl_rise && !drv && !filt.sda
        && !bus_start && !bus_stop |=> st == SFA_IGNORE && !drv)
        else $error("arbitration loss not handled");
    a_idle_released: assert property (st == SFA_IDLE |-> !drv) // see R4
        else $error("data pin driven while idle");
    a_read_to_tx: assert property (                             // see R1
        ce && st == SFA_ADDR_ACK && scl_fall && rw && !bus_start
        && !bus_stop |=> st == SFA_TX)
        else $error("read address did not start transmit");

endmodule : sfa_slave

// >>> tb/sfa_host_model.sv
// Host master model that clocks the serial bus of the slave
`timescale 1ns/100ps

module sfa_host_model (
    // Clock and wire level
    input  wire logic clk,
    input  wire logic sda,
    // Host drives, the clock stands high outside frames
    output logic      scl,
    output logic      sda_drv
);
    // ==========================================================
    // Bus idle with both lines released
    initial begin
        scl     = 1'b1;
        sda_drv = 1'b1;
    end

    // Half period of the bus clock, 8 system clocks
    task automatic hw();
        repeat (8) @(posedge clk);
        #1;
    endtask : hw

    // Start or repeated start
    task automatic start();
        sda_drv = 1'b1;
        hw();
        scl = 1'b1;
        hw();
        sda_drv = 1'b0;
        hw();
        scl = 1'b0;
        hw();
    endtask : start

    // Stop from clock low
    task automatic stop();
        sda_drv = 1'b0;
        hw();
        scl = 1'b1;
        hw();
        sda_drv = 1'b1;
        hw();
    endtask : stop

    // One clock pulse; data moves a cycle after the clock fell
    task automatic bit_xfer(input logic b, output logic s);
        @(posedge clk);
        #1 sda_drv = b;
        hw();
        scl = 1'b1;
        hw();
        s = sda;
        scl = 1'b0;
    endtask : bit_xfer

    // Byte out MSB first, then the slave's acknowledge slot
    task automatic send_byte(input logic [7:0] b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], s);
        end
        bit_xfer(1'b1, s);
        acked = ~s;
    endtask : send_byte

    // Byte in; pull marks bits forced low by a rival slave
    task automatic recv_byte(input logic [7:0] pull, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(~pull[i], s);
            b[i] = s;
        end
        bit_xfer(1'b1, s);
    endtask : recv_byte
endmodule : sfa_host_model

// >>> tb/sfa_slave_tb.sv
// Self-checking bench of the fault alert serial slave
`timescale 1ns/100ps

module sfa_slave_tb
    import sfa_pkg::*;
;
    logic          clk, nrst, ce, scl, sda_drv, sda_wire, sel, mask;
    logic          sdo, sdo_oe_n, al_out, al_oe_n, strobe, chan_b, last_chb;
    logic [7:0]    cmd, last_cmd;
    sfa_fault_type fault;
    int            n_fail, checks_done, n_strobe, seed;

    // Wired AND of both parties with a pull-up
    assign sda_wire = sda_drv & sdo_oe_n;

    sfa_slave dut_u (
        .clk(clk), .nrst(nrst), .ce(ce),
        .serial_clock_pin(scl), .serial_data_in(sda_wire),
        .serial_data_out(sdo), .serial_data_oe_n(sdo_oe_n),
        .alert_out(al_out), .alert_oe_n(al_oe_n),
        .fault_in(fault), .addr_select_pin(sel),
        .fault_alert_mask(mask), .cmd_byte(cmd),
        .cmd_strobe(strobe), .cmd_channel_b(chan_b)
    );

    sfa_host_model host_u (
        .clk(clk), .sda(sda_wire), .scl(scl), .sda_drv(sda_drv)
    );

    // ==========================================================
    // Clock, command capture and watchdog
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    always @(posedge clk) begin
        if (strobe === 1'b1) begin
            n_strobe++;
            last_cmd = cmd;
            last_chb = chan_b;
        end
    end

    initial begin
        #500000;
        n_fail++;
        give_verdict();
    end

    // ==========================================================
    // Compares, verdict and expectations
    task automatic chk_byte(input logic [7:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : chk_byte

    task automatic chk_bit(input logic got, exp, input string what);
        chk_byte({7'h00, got}, {7'h00, exp}, what);
    endtask : chk_bit

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : give_verdict

    function automatic logic [7:0] exp_status(sfa_fault_type f);
        return {f.thermal | f.uvlo, f.logic_a, f.prog_a, f.logic_b,
                f.prog_b, 3'b000};
    endfunction : exp_status

    function automatic logic [7:0] exp_ret(sfa_fault_type f, logic s);
        logic b_only;
        b_only = (f.logic_b | f.prog_b) & ~(f.logic_a | f.prog_a);
        return {5'b10100, s, b_only, 1'b0};
    endfunction : exp_ret

    function automatic logic [6:0] own(logic chb);
        return {5'b10100, sel, chb};
    endfunction : own

    // Addressed read, data compared when no rival pulls the line
    task automatic read_op(input logic [6:0] a, input logic ack_exp,
                           input logic [7:0] exp, pull);
        logic       acked;
        logic [7:0] b;
        host_u.start();
        host_u.send_byte({a, 1'b1}, acked);
        chk_bit(acked, ack_exp, "read address ack");
        if (acked === 1'b1) begin
            host_u.recv_byte(pull, b);
            if (pull == 8'h00) chk_byte(b, exp, "read data");
        end
        host_u.stop();
    endtask : read_op

    // Addressed write of one byte, left open for a repeated start
    task automatic write_op(input logic [6:0] a, input logic [7:0] d,
                            input logic ack_exp);
        logic acked;
        host_u.start();
        host_u.send_byte({a, 1'b0}, acked);
        chk_bit(acked, ack_exp, "write address ack");
        if (acked === 1'b1) begin
            host_u.send_byte(d, acked);
            chk_bit(acked, 1'b1, "write data ack");
        end
    endtask : write_op

    // ==========================================================
    // Main sequence
    initial begin
        sfa_fault_type fa, fb;
        logic [7:0]    d;
        seed = 52871;
        n_fail = 0;
        checks_done = 0;
        n_strobe = 0;
        nrst = 1'b0;
        ce = 1'b1;
        fault = '0;
        mask = 1'b0;
        sel = 1'b0;
        repeat (3) @(posedge clk);
        #1 nrst = 1'b1;
        chk_bit(al_oe_n, 1'b1, "alert after reset");
        chk_bit(sdo_oe_n, 1'b1, "data after reset");
        read_op(own(0), 1'b1, 8'h00, 8'h00);
        read_op(SFA_POINTER_ADDR, 1'b0, 8'h00, 8'h00);
        for (int k = 0; k < 4; k++) begin
            sel = 1'($random(seed));
            fa = (k == 0) ? 6'h03 : 6'($random(seed));
            if (fa == '0) fa = 6'h20;
            fb = 6'($random(seed)) | 6'h01;
            fault = fa;
            host_u.hw();
            chk_bit(al_oe_n, 1'b0, "alert on fault");
            fault = '0;
            host_u.hw();
            chk_bit(al_oe_n, 1'b0, "alert held");
            fault = fb;
            host_u.hw();
            fault = '0;
            read_op(SFA_POINTER_ADDR, 1'b1, exp_ret(fa, sel), 8'h00);
            host_u.hw();
            chk_bit(al_oe_n, 1'b1, "alert released");
            read_op(own(0), 1'b1, exp_status(fa), 8'h00);
            read_op(own(0), 1'b1, 8'h00, 8'h00);
        end
        fault = 6'h10;
        host_u.hw();
        read_op(SFA_POINTER_ADDR, 1'b1, exp_ret(6'h10, sel), 8'h00);
        host_u.hw();
        chk_bit(al_oe_n, 1'b0, "alert again");
        fault = 6'h18;
        read_op(own(0), 1'b1, exp_status(6'h10), 8'h00);
        read_op(own(0), 1'b1, exp_status(6'h18), 8'h00);
        fault = '0;
        read_op(own(0), 1'b1, exp_status(6'h18), 8'h00);
        read_op(SFA_POINTER_ADDR, 1'b1, exp_ret(6'h10, sel), 8'h00);
        sel = 1'b1;
        fault = 6'h20;
        host_u.hw();
        fault = '0;
        read_op(SFA_POINTER_ADDR, 1'b1, 8'h00, 8'h04);
        host_u.hw();
        chk_bit(al_oe_n, 1'b0, "loser keeps alert");
        read_op(SFA_POINTER_ADDR, 1'b1, exp_ret(6'h20, 1'b1), 8'h00);
        read_op(own(0), 1'b1, exp_status(6'h20), 8'h00);
        mask = 1'b1;
        fault = 6'h02;
        host_u.hw();
        fault = '0;
        host_u.hw();
        chk_bit(al_oe_n, 1'b1, "masked alert");
        mask = 1'b0;
        read_op(own(0), 1'b1, exp_status(6'h02), 8'h00);
        for (int c = 0; c < 2; c++) begin
            d = 8'($random(seed));
            write_op(own(c[0]), d, 1'b1);
            read_op(own(0), 1'b1, 8'h00, 8'h00);
            chk_byte(last_cmd, d, "command byte");
            chk_bit(last_chb, c[0], "command channel");
        end
        write_op(SFA_POINTER_ADDR, 8'h5A, 1'b0);
        host_u.stop();
        read_op(own(1), 1'b0, 8'h00, 8'h00);
        read_op(7'h2B, 1'b0, 8'h00, 8'h00);
        chk_byte(8'(n_strobe), 8'h02, "strobe count");
        chk_bit(al_out | sdo, 1'b0, "open drain level");
        ce = 1'b0;
        fault = 6'h01;
        host_u.hw();
        fault = '0;
        ce = 1'b1;
        host_u.hw();
        chk_bit(al_oe_n, 1'b1, "fault unseen while frozen");
        fault = 6'h08;
        host_u.hw();
        fault = '0;
        nrst = 1'b0;
        host_u.hw();
        nrst = 1'b1;
        chk_bit(al_oe_n, 1'b1, "alert after mid reset");
        read_op(own(0), 1'b1, 8'h00, 8'h00);
        give_verdict();
    end
endmodule : sfa_slave_tb
